// ==== core/jtl_pkg.sv ====
package jtl_pkg;

   // instruction encodings
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_REGION_JUMP = 6'h02;
   localparam logic [5:0] OP_REGION_JUMP_LINK = 6'h03;
   localparam logic [5:0] FN_REG_JUMP_LINK = 6'h09;

   // instruction field positions
   localparam int OPC_MSB = 31;
   localparam int OPC_LSB = 26;
   localparam int SRC_MSB = 25;
   localparam int SRC_LSB = 21;
   localparam int DST_MSB = 15;
   localparam int DST_LSB = 11;
   localparam int IDX_MSB = 25;
   localparam int FN_MSB = 5;
   localparam int BARRIER_BIT = 10;
   localparam int REGION_LSB = 28;

   // link figures
   localparam logic [4:0] LINK_REG_DEFAULT = 5'h1f;
   localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
   localparam logic [31:0] SLOT_OFFSET = 32'h0000_0004;

   // register map, byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_LAST_TARGET = 8'h0c;

   // control field positions and reset values
   localparam int CTRL_CA_BIT = 0;
   localparam int CTRL_REL2_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // status field positions
   localparam int STAT_ISA_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_AERR_BIT = 2;
   localparam int STAT_HAZ_BIT = 3;

   typedef enum logic [1:0] {
      JK_NONE,
      JK_REGION,
      JK_REGISTER
   } jtl_kind_type;

endpackage

// ==== core/jtl_dec_if.sv ====
`timescale 1ns/1ns
interface jtl_dec_if;
   jtl_pkg::jtl_kind_type kind;
   logic link;
   logic barrier_bit;
   logic [25:0] index;
   logic [4:0] dst_sel;

   modport decoder (output kind, output link, output barrier_bit, output index, output dst_sel);
   modport user (input kind, input link, input barrier_bit, input index, input dst_sel);
endinterface

// ==== core/jtl_decode.sv ====
`timescale 1ns/1ns
module jtl_decode (
   // instruction word
   input wire logic [31:0] instr,
   // decoded view
   jtl_dec_if.decoder dec
);
   logic [5:0] opc;
   logic [5:0] fn;
   logic is_region;
   logic is_region_link;
   logic is_reg_link;

   // field extraction
   assign opc = instr[jtl_pkg::OPC_MSB:jtl_pkg::OPC_LSB];
   assign fn = instr[jtl_pkg::FN_MSB:0];
   assign is_region = (opc == jtl_pkg::OP_REGION_JUMP);
   assign is_region_link = (opc == jtl_pkg::OP_REGION_JUMP_LINK);
   assign is_reg_link = (opc == jtl_pkg::OP_SPECIAL) && (fn == jtl_pkg::FN_REG_JUMP_LINK);

   // kind and link selection
   assign dec.kind = (is_region || is_region_link) ? jtl_pkg::JK_REGION :
                     is_reg_link ? jtl_pkg::JK_REGISTER : jtl_pkg::JK_NONE;
   assign dec.link = is_region_link || is_reg_link;
   // upper hint bit marks the barrier form
   assign dec.barrier_bit = is_reg_link && instr[jtl_pkg::BARRIER_BIT]; // [RULE17]
   assign dec.index = instr[jtl_pkg::IDX_MSB:0];
   // region link always goes to register 31
   assign dec.dst_sel = is_region_link ? jtl_pkg::LINK_REG_DEFAULT
                                       : instr[jtl_pkg::DST_MSB:jtl_pkg::DST_LSB]; // [RULE6]
endmodule

// ==== core/jtl_top.sv ====
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
// Behaviour
// RULE1: region jumps take low 28 target bits from index shifted left two.
// RULE2: upper target bits come from the delay-slot address, not the jump's.
// RULE3: the delay-slot instruction issues before the redirect to the target.
// RULE4: a jump in a region's last word lands in the following region.
// RULE5: software keeps branches, jumps, returns and wait out of delay slots.
// RULE6: region jump-with-link writes jump address plus 8 into register 31.
// RULE7: register jump-with-link writes the second-next address into the chosen register.
// RULE8: assembler defaults the link destination to register 31.
// RULE9: with compressed support, bit 0 sets the mode and target bit 0 clears.
// RULE10: without compressed support, misaligned low bits fault when the target is fetched.
// RULE11: with compressed support, low bits 10 fault when the target is fetched.
// RULE12: first release ignores the hint; second release uses bit 10 as barrier.
// RULE13: software never uses equal source and destination in register jump-with-link.
// RULE14: barrier form clears hazards before the target is fetched and decoded.
// RULE15: barrier form is legal in every mode with no coprocessor check.
// RULE16: barrier clears only hazards from before the jump, not its slot.
// RULE17: barrier form is recognised by instruction bit 10.
// RULE18: software clears instruction hazards after changing instruction memory or mapping.
// RULE19: source value is captured before link write; compressed mode set by config bit.
module jtl_top (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // issue stage
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   input wire logic [31:0] issue_pc,
   input wire logic [31:0] src_value,
   // pipeline progress
   input wire logic slot_issued,
   input wire logic target_fetch,
   input wire logic hazard_done,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // jump unit outputs
   output logic jump_busy,
   output logic link_we,
   output logic [4:0] link_addr,
   output logic [31:0] link_data,
   output logic redirect_valid,
   output logic [31:0] redirect_pc,
   output logic compressed_isa_flag,
   output logic hazard_clear_req,
   output logic fetch_addr_error
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SLOT,
      ST_HAZARD,
      ST_FETCH
   } jtl_state_type;

   // misaligned fetch check; compressed mode tolerates an odd target
   function automatic logic jtl_misaligned(input logic [31:0] tgt, input logic ca);
      logic bad;
      if (ca) begin
         bad = (tgt[1:0] == 2'b10); // [RULE11]
      end else begin
         bad = (tgt[1:0] != 2'b00); // [RULE10]
      end
      return bad;
   endfunction

   jtl_dec_if dec_bus ();

   jtl_decode u_decode (
      .instr(issue_instr),
      .dec(dec_bus.decoder)
   );

   jtl_state_type state_q;
   jtl_state_type state_d;
   logic [1:0] ctrl_q;
   logic [31:0] target_q;
   logic [31:0] target_d;
   logic aerr_pend_q;
   logic aerr_pend_d;
   logic isa_next_q;
   logic isa_next_d;
   logic barrier_q;
   logic haz_seen_q;
   logic aerr_sticky_q;
   logic [31:0] count_q;
   logic [31:0] last_target_q;
   logic busy_q;
   logic link_we_q;
   logic [4:0] link_addr_q;
   logic [31:0] link_data_q;
   logic redirect_q;
   logic [31:0] redirect_pc_q;
   logic isa_q;
   logic haz_req_q;
   logic fetch_err_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // configuration view
   wire ca_on = ctrl_q[jtl_pkg::CTRL_CA_BIT];
   wire rel2_on = ctrl_q[jtl_pkg::CTRL_REL2_BIT];

   // jump acceptance; no privilege or coprocessor gate on any form
   wire is_jump = (dec_bus.kind != jtl_pkg::JK_NONE);
   wire accept = issue_valid && is_jump && (state_q == ST_IDLE); // [RULE15]

   // first release ignores the hint field entirely
   wire use_barrier = dec_bus.barrier_bit && rel2_on; // [RULE12]

   // delay-slot address supplies the region bits
   wire [31:0] slot_pc = issue_pc + jtl_pkg::SLOT_OFFSET; // [RULE2]
   // carry out of the last word moves into the next region
   wire [31:0] region_tgt = {slot_pc[31:jtl_pkg::REGION_LSB],
                             dec_bus.index, 2'b00}; // [RULE1] [RULE4]

   // register target with optional compressed mode handling
   wire [31:0] reg_tgt = ca_on ? {src_value[31:1], 1'b0} : src_value; // [RULE9] [RULE19]
   wire reg_isa = ca_on ? src_value[0] : 1'b0; // [RULE9]

   // link value is the second instruction after the jump
   wire [31:0] link_value = issue_pc + jtl_pkg::LINK_OFFSET; // [RULE6] [RULE7]

   // slot and hazard conditions for leaving the wait states
   wire haz_ok = !barrier_q || haz_seen_q || hazard_done;
   wire slot_go = (state_q == ST_SLOT) && slot_issued;

   // ahb address phase decode
   wire ahb_take = hsel && htrans[1] && hready;
   wire [7:0] ahb_ofs = haddr[7:0];
   wire ahb_rd = ahb_take && !hwrite;
   wire ahb_wr = ahb_take && hwrite;

   // status word built from live state
   wire [31:0] status_word = {28'h0000000,
                              barrier_q,
                              aerr_sticky_q,
                              busy_q,
                              isa_q};

   // register read selection; unmapped words read as zero
   wire [31:0] rd_mux = (ahb_ofs == jtl_pkg::OFS_CTRL) ? {30'h0, ctrl_q} :
                        (ahb_ofs == jtl_pkg::OFS_STATUS) ? status_word :
                        (ahb_ofs == jtl_pkg::OFS_COUNT) ? count_q :
                        (ahb_ofs == jtl_pkg::OFS_LAST_TARGET) ? last_target_q :
                        32'h00000000;

   // target capture at acceptance, held otherwise
   always_comb begin
      target_d = target_q;
      aerr_pend_d = aerr_pend_q;
      isa_next_d = isa_next_q;
      if (accept) begin
         if (dec_bus.kind == jtl_pkg::JK_REGION) begin
            target_d = region_tgt;
            aerr_pend_d = 1'b0;
            isa_next_d = isa_q;
         end else begin
            target_d = reg_tgt;
            // fault is held and raised only when the target is fetched
            aerr_pend_d = jtl_misaligned(src_value, ca_on); // [RULE10] [RULE11]
            isa_next_d = reg_isa;
         end
      end
   end

   // sequencing: jump, delay slot, optional barrier wait, redirect
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_SLOT;
            end
         end
         ST_SLOT: begin
            // redirect waits until the slot instruction has issued
            if (slot_issued) begin // [RULE3]
               state_d = haz_ok ? ST_FETCH : ST_HAZARD;
            end
         end
         ST_HAZARD: begin
            // target fetch must not start before the barrier completes
            if (hazard_done) begin // [RULE14]
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (target_fetch) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state and captured jump
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         target_q <= 32'h00000000;
         aerr_pend_q <= 1'b0;
         isa_next_q <= 1'b0;
      end else begin
         state_q <= state_d;
         target_q <= target_d;
         aerr_pend_q <= aerr_pend_d;
         isa_next_q <= isa_next_d;
      end
   end

   // barrier bookkeeping; done seen early still counts
   always_ff @(posedge mclk) begin
      if (srst) begin
         barrier_q <= 1'b0;
         haz_seen_q <= 1'b0;
      end else if (accept) begin
         barrier_q <= use_barrier;
         haz_seen_q <= 1'b0;
      end else if (state_q == ST_FETCH && target_fetch) begin
         barrier_q <= 1'b0;
         haz_seen_q <= 1'b0;
      end else if (hazard_done && barrier_q) begin
         haz_seen_q <= 1'b1;
      end
   end

   // barrier request goes out with the jump, before its slot runs
   always_ff @(posedge mclk) begin
      if (srst) begin
         haz_req_q <= 1'b0;
      end else begin
         haz_req_q <= accept && use_barrier; // [RULE16] [RULE14]
      end
   end

   // link write: one pulse in the cycle after the jump is accepted, after source capture
   always_ff @(posedge mclk) begin
      if (srst) begin
         link_we_q <= 1'b0;
         link_addr_q <= 5'h00;
         link_data_q <= 32'h00000000;
      end else begin
         link_we_q <= accept && dec_bus.link; // [RULE7] [RULE19]
         if (accept && dec_bus.link) begin
            link_addr_q <= dec_bus.dst_sel; // [RULE6] [RULE7]
            link_data_q <= link_value;
         end
      end
   end

   // redirect pulse once the slot and any barrier are done
   always_ff @(posedge mclk) begin
      if (srst) begin
         redirect_q <= 1'b0;
         redirect_pc_q <= 32'h00000000;
      end else begin
         redirect_q <= (slot_go && haz_ok) ||
                       (state_q == ST_HAZARD && hazard_done); // [RULE3] [RULE14]
         if (state_q == ST_SLOT || state_q == ST_HAZARD) begin
            redirect_pc_q <= target_q;
         end
      end
   end

   // mode bit follows the target at the target fetch, after the redirect
   always_ff @(posedge mclk) begin
      if (srst) begin
         isa_q <= 1'b0;
      end else if (state_q == ST_FETCH && target_fetch) begin
         isa_q <= isa_next_q; // [RULE9]
      end
   end

   // address fault raised at the fetch of the target
   always_ff @(posedge mclk) begin
      if (srst) begin
         fetch_err_q <= 1'b0;
         aerr_sticky_q <= 1'b0;
      end else begin
         fetch_err_q <= (state_q == ST_FETCH) && target_fetch && aerr_pend_q; // [RULE10] [RULE11]
         if ((state_q == ST_FETCH) && target_fetch && aerr_pend_q) begin
            aerr_sticky_q <= 1'b1;
         end else if (wr_pend_q && wr_addr_q == jtl_pkg::OFS_STATUS &&
                      hwdata[jtl_pkg::STAT_AERR_BIT]) begin
            aerr_sticky_q <= 1'b0;
         end
      end
   end

   // busy holds further issue until the target fetch starts
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != ST_IDLE);
      end
   end

   // jump count and last target for software view
   always_ff @(posedge mclk) begin
      if (srst) begin
         count_q <= 32'h00000000;
         last_target_q <= 32'h00000000;
      end else if (accept) begin
         count_q <= count_q + 32'h00000001;
         last_target_q <= target_d;
      end
   end

   // ahb address phase capture; zero wait states, answer always ready and okay
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         wr_pend_q <= ahb_wr;
         if (ahb_wr) begin
            wr_addr_q <= ahb_ofs;
         end
         if (ahb_rd) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // control write in the data phase; status writes with the fault bit set clear the sticky fault, other offsets ignore writes
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_q <= jtl_pkg::CTRL_RESET;
      end else if (wr_pend_q && wr_addr_q == jtl_pkg::OFS_CTRL) begin
         ctrl_q <= hwdata[1:0]; // [RULE19]
      end
   end

   // output drive straight from flops
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign jump_busy = busy_q;
   assign link_we = link_we_q;
   assign link_addr = link_addr_q;
   assign link_data = link_data_q;
   assign redirect_valid = redirect_q;
   assign redirect_pc = redirect_pc_q;
   assign compressed_isa_flag = isa_q;
   assign hazard_clear_req = haz_req_q;
   assign fetch_addr_error = fetch_err_q;
endmodule

// ==== test/jtl_properties.sv ====
`timescale 1ns/1ns
module jtl_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // issue and pipeline progress
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   input wire logic [31:0] issue_pc,
   input wire logic slot_issued,
   input wire logic target_fetch,
   input wire logic hazard_done,
   // jump unit outputs
   input wire logic jump_busy,
   input wire logic link_we,
   input wire logic [4:0] link_addr,
   input wire logic [31:0] link_data,
   input wire logic redirect_valid,
   input wire logic [31:0] redirect_pc,
   input wire logic compressed_isa_flag,
   input wire logic hazard_clear_req,
   input wire logic fetch_addr_error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // accepted jump decode
   wire [5:0] op = issue_instr[31:26];
   wire [4:0] dst = issue_instr[15:11];
   wire rlink = op == 6'h00 && issue_instr[5:0] == 6'h09;
   wire acc = issue_valid && !jump_busy && (op == 6'h02 || op == 6'h03 || rlink);
   wire acc_hb = acc && rlink && issue_instr[10];
   wire [31:0] slot_pc = issue_pc + 32'h0000_0004;
   logic region_q;
   logic slot_q;
   logic haz_q;
   logic [31:0] tgt_q;
   // expected target and progress; a pending barrier must hold the redirect back
   always_ff @(posedge mclk) begin
      if (srst) begin
         region_q <= 1'b0;
         slot_q <= 1'b0;
         haz_q <= 1'b0;
         tgt_q <= 32'h0000_0000;
      end else begin
         if (acc) begin
            region_q <= op != 6'h00;
            slot_q <= 1'b0;
            tgt_q <= {slot_pc[31:28], issue_instr[25:0], 2'b00};
         end else if (slot_issued) begin
            slot_q <= 1'b1;
         end
         if (hazard_clear_req) begin
            haz_q <= 1'b1;
         end else if (hazard_done) begin
            haz_q <= 1'b0;
         end
      end
   end
   a_region_target:
   assert property (redirect_valid && region_q |-> redirect_pc == tgt_q)
      else $error("region target wrong");
   a_slot_first:
   assert property (redirect_valid |-> slot_q) else $error("redirect before slot");
   a_region_link:
   assert property (acc && op == 6'h03 |=> link_we && link_addr == 5'h1f
      && link_data == $past(issue_pc) + 32'h0000_0008) else $error("region link wrong");
   a_reg_link:
   assert property (acc && rlink |=> link_we && link_addr == $past(dst))
      else $error("register link wrong");
   a_barrier_req:
   assert property (hazard_clear_req |-> $past(acc_hb)) else $error("stray clear request");
   a_barrier_wait:
   assert property (redirect_valid |-> !haz_q) else $error("redirect before hazards clear");
   a_redirect_prompt:
   assert property (slot_issued && jump_busy && !haz_q && !hazard_clear_req |=> redirect_valid)
      else $error("redirect late");
   a_fault_timing:
   assert property (fetch_addr_error |-> $past(target_fetch)) else $error("fault not at fetch");
   a_mode_at_fetch:
   assert property ($changed(compressed_isa_flag) |-> $past(target_fetch))
      else $error("mode changed off fetch");
endmodule
bind jtl_top jtl_properties i_jtl_properties (.mclk, .srst, .issue_valid, .issue_instr,
   .issue_pc, .slot_issued, .target_fetch, .hazard_done, .jump_busy, .link_we, .link_addr,
   .link_data, .redirect_valid, .redirect_pc, .compressed_isa_flag, .hazard_clear_req,
   .fetch_addr_error);

// ==== test/jtl_fetch_model.sv ====
`timescale 1ns/1ns
module jtl_fetch_model (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // pacing
   input wire logic slow,
   // jump unit view
   input wire logic jump_busy,
   input wire logic redirect_valid,
   input wire logic hazard_clear_req,
   // progress pulses
   output logic slot_issued = 1'b0,
   output logic target_fetch = 1'b0,
   output logic hazard_done = 1'b0
);
   logic [2:0] ph_q = 3'h0;
   logic [2:0] wait_q = 3'h0;
   logic haz_q = 1'b0;
   // slot, then hazard clearing, then fetch of the redirect
   always @(posedge mclk) begin
      slot_issued <= 1'b0;
      target_fetch <= 1'b0;
      hazard_done <= 1'b0;
      if (srst) begin
         ph_q <= 3'h0;
         wait_q <= 3'h0;
         haz_q <= 1'b0;
      end else begin
         if (hazard_clear_req) haz_q <= 1'b1;
         if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end else begin
            case (ph_q)
               3'h0: if (jump_busy) begin
                  ph_q <= 3'h1;
                  wait_q <= slow ? 3'h3 : 3'h0;
               end
               3'h1: begin
                  slot_issued <= 1'b1; // slot is never a jump
                  ph_q <= 3'h2;
                  wait_q <= slow ? 3'h3 : 3'h0;
               end
               3'h2: begin
                  hazard_done <= haz_q; // tracker finishes the clearing
                  haz_q <= 1'b0;
                  ph_q <= 3'h3;
               end
               3'h3: if (redirect_valid) begin
                  target_fetch <= 1'b1;
                  ph_q <= 3'h4;
               end
               default: if (!jump_busy) ph_q <= 3'h0;
            endcase
         end
      end
   end
endmodule

// ==== test/jtl_top_tb.sv ====
`timescale 1ns/1ns
module jtl_top_tb;
   logic mclk, srst, issue_valid, slot_issued, target_fetch, hazard_done, hsel, hwrite, slow;
   logic [31:0] issue_instr, issue_pc, src_value, haddr, hwdata, hrdata, redirect_pc;
   logic [31:0] link_data, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] link_addr;
   logic hreadyout, hresp, jump_busy, link_we, redirect_valid, compressed_isa_flag;
   logic hazard_clear_req, fetch_addr_error;
   int num_errors, n_compared;
   jtl_top i_jtl_top (.mclk, .srst, .issue_valid, .issue_instr, .issue_pc, .src_value,
      .slot_issued, .target_fetch, .hazard_done, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .jump_busy, .link_we,
      .link_addr, .link_data, .redirect_valid, .redirect_pc, .compressed_isa_flag,
      .hazard_clear_req, .fetch_addr_error);
   jtl_fetch_model i_jtl_fetch_model (.mclk, .srst, .slow, .jump_busy, .redirect_valid,
      .hazard_clear_req, .slot_issued, .target_fetch, .hazard_done);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single word transfer; waits on the slave answer, not on a fixed count
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp(32'(hresp), 32'h0);
   endtask
   // register jump-link, source and destination kept apart
   function automatic logic [31:0] rj(input logic [4:0] s, d, input logic b);
      return {6'h00, s, 5'h00, d, b, 4'h0, 6'h09};
   endfunction
   // issue one jump, follow it to the end and judge every output
   task automatic run_jump(input logic [31:0] ins, pc, src, tgt, input logic [4:0] la,
         input int nl, nh, input logic er, fl, dup);
      int l, h;
      logic e;
      logic [4:0] lg;
      logic [31:0] ld, rp;
      l = 0;
      h = 0;
      e = 1'b0;
      lg = 5'h00;
      ld = 32'h0;
      rp = 32'hffff_ffff;
      @(posedge mclk);
      issue_valid <= 1'b1;
      issue_instr <= ins;
      issue_pc <= pc;
      src_value <= src;
      @(posedge mclk);
      issue_valid <= dup;
      issue_pc <= pc + 32'h0000_0100;
      src_value <= ~src; // late source change must not move the target
      repeat (60) begin
         #1;
         if (link_we === 1'b1) begin
            l++;
            lg = link_addr;
            ld = link_data;
         end
         if (hazard_clear_req === 1'b1) h++;
         if (redirect_valid === 1'b1) rp = redirect_pc;
         if (fetch_addr_error === 1'b1) e = 1'b1;
         if (jump_busy !== 1'b1) break;
         @(posedge mclk);
         issue_valid <= 1'b0;
      end
      cmp(rp, tgt);
      cmp(32'(l), 32'(nl));
      if (nl > 0) begin
         cmp(32'(lg), 32'(la));
         cmp(ld, pc + 32'h0000_0008);
      end
      cmp(32'(h), 32'(nh));
      cmp(32'(e), 32'(er));
      cmp(32'(compressed_isa_flag), 32'(fl));
   endtask
   task automatic t_regs;
      ahb(1'b0, 32'h0, 32'h0);
      cmp(rd, 32'h3);
      ahb(1'b1, 32'h8, 32'hffff_ffff);
      ahb(1'b0, 32'h8, 32'h0);
      cmp(rd, 32'h0);
      ahb(1'b0, 32'h10, 32'h0);
      cmp(rd, 32'h0);
   endtask
   task automatic t_region;
      run_jump({6'h02, 26'h10}, 32'h0fff_fffc, 0, 32'h1000_0040, 0, 0, 0, 0, 0, 0);
   endtask
   task automatic t_link_busy;
      run_jump({6'h03, 26'h3ffffff}, 32'h20000100, 0, 32'h2ffffffc, 31, 1, 0, 0, 0, 1);
      ahb(1'b0, 32'h8, 32'h0);
      cmp(rd, 32'h2);
   endtask
   task automatic t_reg_link;
      run_jump(rj(3, 5, 0), 32'h400, 32'h1235, 32'h1234, 5, 1, 0, 0, 1, 0);
      run_jump(rj(3, 6, 0), 32'h400, 32'h2002, 32'h2002, 6, 1, 0, 1, 0, 0);
   endtask
   task automatic t_no_comp;
      ahb(1'b1, 32'h0, 32'h2);
      run_jump(rj(3, 7, 0), 32'h800, 32'h3001, 32'h3001, 7, 1, 0, 1, 0, 0);
      run_jump(rj(3, 7, 0), 32'h800, 32'h3002, 32'h3002, 7, 1, 0, 1, 0, 0);
      // sticky fault and last target as software sees them, then write-one-to-clear
      ahb(1'b0, 32'h4, 32'h0);
      cmp(rd, 32'h4);
      ahb(1'b0, 32'hc, 32'h0);
      cmp(rd, 32'h3002);
      ahb(1'b1, 32'h4, 32'h4);
      ahb(1'b0, 32'h4, 32'h0);
      cmp(rd, 32'h0);
   endtask
   task automatic t_barrier;
      ahb(1'b1, 32'h0, 32'h3);
      slow <= 1'b1;
      run_jump(rj(4, 31, 1), 32'h900, 32'h5000, 32'h5000, 31, 1, 1, 0, 0, 0);
      ahb(1'b1, 32'h0, 32'h1);
      run_jump(rj(4, 31, 1), 32'h900, 32'h5000, 32'h5000, 31, 1, 0, 0, 0, 0);
      slow <= 1'b0;
   endtask
   task automatic summarize;
      if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      {srst, hsize} = 4'ha;
      {issue_valid, hsel, hwrite, slow, htrans} = 6'h00;
      {issue_instr, issue_pc, src_value, haddr, hwdata} = '0;
      num_errors = 0;
      n_compared = 0;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_region();
      t_link_busy();
      t_reg_link();
      t_no_comp();
      t_barrier();
      summarize();
   end
   // the run needs about a hundred and seventy cycles; allow ten thousand
   initial begin
      #400000;
      num_errors++;
      summarize();
   end
endmodule
